// File: hw/fault_monitor_pkg.sv
package fault_monitor_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned TICK_PERIOD_NS = 1000000;
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned SIMUL_LIMIT_S  = 3;
  localparam int unsigned SIMUL_LIMIT_MS = SIMUL_LIMIT_S * 1000;
  localparam int unsigned PAIR_LIMIT_MS  = 500;

  // ----------------------------------------------------------------------
  // input wiring modes
  // ----------------------------------------------------------------------
  localparam logic [1:0] MODE_DUAL      = 2'h0;
  localparam logic [1:0] MODE_COMPL     = 2'h1;
  localparam logic [1:0] MODE_DUAL_COMP = 2'h2;

  // ----------------------------------------------------------------------
  // fault codes
  // ----------------------------------------------------------------------
  localparam logic [7:0]  ERR_NONE        = 8'h00;
  localparam logic [7:0]  ERR_OUTPUT      = 8'h01;
  localparam logic [7:0]  ERR_INPUT       = 8'h02;
  localparam logic [7:0]  ADV_SEQ_TIMING  = 8'h0A;
  localparam logic [7:0]  ADV_CONC_OUTER  = 8'h01;
  localparam logic [7:0]  ADV_SIMUL_OUTER = 8'h02;
  localparam logic [7:0]  ADV_CONC_PAIR_A = 8'h03;
  localparam logic [7:0]  ADV_SIMUL_PAIR_A= 8'h04;
  localparam logic [7:0]  ADV_CONC_PAIR_B = 8'h05;
  localparam logic [7:0]  ADV_SIMUL_PAIR_B= 8'h06;
  localparam logic [15:0] INDEX_MAJOR_MUL = 16'h0064;

  // ----------------------------------------------------------------------
  // pair monitor states
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_WAIT = 5'h02,
    ST_RUN  = 5'h04,
    ST_DROP = 5'h08,
    ST_LOCK = 5'h10
  } mon_state_e;

endpackage : fault_monitor_pkg

// File: hw/pair_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module pair_monitor #(
  parameter int unsigned LIMIT_TICKS = 3000,
  parameter int unsigned CNT_W       = 16
) (
  input  wire logic clk_in,
  input  wire logic srst_in,
  input  wire logic enable_in,
  input  wire logic tick_in,
  input  wire logic a_run_in,
  input  wire logic b_run_in,
  output logic      run_out,
  output logic      locked_out,
  output logic      conc_out,
  output logic      simul_out
);

  generate
    if (LIMIT_TICKS < 1 || LIMIT_TICKS >= (64'h1 << CNT_W))
    begin : g_bad_limit
      $error("pair_monitor: LIMIT_TICKS does not fit CNT_W");
    end
  endgenerate

  localparam logic [CNT_W-1:0] LAST = CNT_W'(LIMIT_TICKS - 1);

  fault_monitor_pkg::mon_state_e state;
  logic [CNT_W-1:0]              cnt;
  logic                          a_drop;
  logic                          both;
  logic                          none;

  assign both = a_run_in & b_run_in;
  assign none = ~a_run_in & ~b_run_in;

  // ----------------------------------------------------------------------
  // sequence tracking
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    conc_out  <= 1'b0;
    simul_out <= 1'b0;
    if (srst_in || !enable_in)
    begin
      state <= fault_monitor_pkg::ST_IDLE;
      cnt   <= '0;
      a_drop <= 1'b0;
    end
    else
    begin
      case (state)
        fault_monitor_pkg::ST_IDLE:
        begin
          cnt <= '0;
          if (both)
            state <= fault_monitor_pkg::ST_RUN;
          else if (!none)
            state <= fault_monitor_pkg::ST_WAIT;
        end
        fault_monitor_pkg::ST_WAIT:
        begin
          if (both)
            state <= fault_monitor_pkg::ST_RUN;
          else if (none)
            state <= fault_monitor_pkg::ST_IDLE;
          else if (tick_in && cnt == LAST)
          begin
            state     <= fault_monitor_pkg::ST_LOCK; // RL7 RL8 RL10
            simul_out <= 1'b1;
          end
          else if (tick_in)
            cnt <= cnt + 1'b1;
        end
        fault_monitor_pkg::ST_RUN:
        begin
          if (none)
            state <= fault_monitor_pkg::ST_IDLE;
          else if (!both)
          begin
            state  <= fault_monitor_pkg::ST_DROP;
            a_drop <= ~a_run_in;
          end
        end
        fault_monitor_pkg::ST_DROP:
        begin
          if (none)
            state <= fault_monitor_pkg::ST_IDLE;
          else if (both)
          begin
            state    <= fault_monitor_pkg::ST_LOCK; // RL5 RL6 RL9
            conc_out <= 1'b1;
          end
          else if (a_drop != ~a_run_in)
            state <= fault_monitor_pkg::ST_LOCK; // RL12
        end
        fault_monitor_pkg::ST_LOCK:
        begin
          cnt <= '0;
          if (none)
            state <= fault_monitor_pkg::ST_IDLE; // RL12
        end
        default:
          state <= fault_monitor_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (srst_in || !enable_in)
    begin
      run_out    <= 1'b0;
      locked_out <= 1'b0;
    end
    else
    begin
      run_out    <= (state == fault_monitor_pkg::ST_RUN) ||
                    (state == fault_monitor_pkg::ST_IDLE && both);
      locked_out <= (state == fault_monitor_pkg::ST_LOCK);
    end
  end

endmodule : pair_monitor
`default_nettype wire

// File: hw/dual_input_fault_monitor.sv
// Behaviour
// RL1: every fault is reported as a major error code and a minor advanced code, major.minor.
// RL2: the message index is the major code ahead of a two-digit minor code (major*100+minor).
// RL3: the whole message index is available in one 16-bit output word.
// RL4: minor code ten and minor code one stay distinct, so 1.10 differs from 1.1 everywhere.
// RL5: dual or complementary input running, one channel drops and returns while the other runs: 2.1.
// RL6: dual-complementary input running, one pair drops and returns to Run: 2.1.
// RL7: dual or complementary input, one channel enters Run and the other misses 3 s: 2.2.
// RL8: dual-complementary input, one pair enters Run and the other pair misses 3 s: 2.2.
// RL9: a complementary pair running drops to Stop and returns: 2.3 (pair A) or 2.5 (pair B); the code does so only when one member drops and returns.
// RL10: a pair member enters Run and its partner misses the pair limit: 2.4 or 2.6.
// RL11: an output sequence-timing error reports 1.10 and holds until system reset.
// RL12: after an input fault the input stays in Stop until all channels stop and re-run together.
`timescale 1ns/100ps
`default_nettype none
module dual_input_fault_monitor #(
  parameter int unsigned TICK_CYCLES = fault_monitor_pkg::TICK_CYCLES,
  parameter int unsigned SIMUL_MS    = fault_monitor_pkg::SIMUL_LIMIT_MS,
  parameter int unsigned PAIR_MS     = fault_monitor_pkg::PAIR_LIMIT_MS
) (
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic [3:0]  chan_in,
  input  wire logic [1:0]  mode_in,
  input  wire logic        seq_err_in,
  output logic             run_out,
  output logic             fault_out,
  output logic             fault_new_out,
  output logic             seq_fault_out,
  output logic [7:0]       err_code_out,
  output logic [7:0]       adv_code_out,
  output logic [15:0]      msg_index_out
);

  generate
    if (TICK_CYCLES < 2 || SIMUL_MS < 1 || PAIR_MS < 1 || SIMUL_MS > 65535 || PAIR_MS > 65535)
    begin : g_bad_param
      $error("dual_input_fault_monitor: unsupported timing parameters");
    end
  endgenerate

  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [3:0] chan_meta;
  logic [3:0] chan;
  logic [1:0] mode_meta;
  logic [1:0] mode;

  always_ff @(posedge clk_in)
  begin
    chan_meta <= chan_in;
    chan      <= chan_meta;
    mode_meta <= mode_in;
    mode      <= mode_meta;
  end

  // ----------------------------------------------------------------------
  // millisecond tick
  // ----------------------------------------------------------------------
  logic [31:0] tick_cnt;
  logic        tick;

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end
    else if (tick_cnt == TICK_LAST)
    begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
      tick     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // run states per channel and pair
  // ----------------------------------------------------------------------
  logic dual_comp;
  logic pair_a_run;
  logic pair_b_run;
  logic outer_a;
  logic outer_b;

  assign dual_comp  = (mode == fault_monitor_pkg::MODE_DUAL_COMP);
  assign pair_a_run = chan[0] & ~chan[1];
  assign pair_b_run = chan[2] & ~chan[3];
  assign outer_a    = dual_comp ? pair_a_run : chan[0];
  assign outer_b    = dual_comp ? pair_b_run :
                      (mode == fault_monitor_pkg::MODE_COMPL) ? ~chan[1] : chan[1];

  // ----------------------------------------------------------------------
  // monitors
  // ----------------------------------------------------------------------
  logic outer_run;
  logic outer_lock;
  logic outer_conc;
  logic outer_simul;
  logic a_run;
  logic a_lock;
  logic a_conc;
  logic a_simul;
  logic b_run;
  logic b_lock;
  logic b_conc;
  logic b_simul;

  pair_monitor #(
    .LIMIT_TICKS (SIMUL_MS),
    .CNT_W       (16)
  ) u_outer (
    .clk_in     (clk_in),
    .srst_in    (srst_in),
    .enable_in  (1'b1),
    .tick_in    (tick),
    .a_run_in   (outer_a),
    .b_run_in   (outer_b),
    .run_out    (outer_run),
    .locked_out (outer_lock),
    .conc_out   (outer_conc),
    .simul_out  (outer_simul)
  );

  pair_monitor #(
    .LIMIT_TICKS (PAIR_MS),
    .CNT_W       (16)
  ) u_pair_a (
    .clk_in     (clk_in),
    .srst_in    (srst_in),
    .enable_in  (dual_comp),
    .tick_in    (tick),
    .a_run_in   (chan[0]),
    .b_run_in   (~chan[1]),
    .run_out    (a_run),
    .locked_out (a_lock),
    .conc_out   (a_conc),
    .simul_out  (a_simul)
  );

  pair_monitor #(
    .LIMIT_TICKS (PAIR_MS),
    .CNT_W       (16)
  ) u_pair_b (
    .clk_in     (clk_in),
    .srst_in    (srst_in),
    .enable_in  (dual_comp),
    .tick_in    (tick),
    .a_run_in   (chan[2]),
    .b_run_in   (~chan[3]),
    .run_out    (b_run),
    .locked_out (b_lock),
    .conc_out   (b_conc),
    .simul_out  (b_simul)
  );

  // ----------------------------------------------------------------------
  // input fault capture
  // ----------------------------------------------------------------------
  logic       any_new;
  logic       any_lock;
  logic [7:0] new_adv;
  logic       in_valid;
  logic [7:0] in_adv;

  assign any_new  = outer_conc | outer_simul | a_conc | a_simul | b_conc | b_simul;
  assign any_lock = outer_lock | a_lock | b_lock;

  always_comb
  begin
    if (a_conc)
      new_adv = fault_monitor_pkg::ADV_CONC_PAIR_A; // RL9
    else if (a_simul)
      new_adv = fault_monitor_pkg::ADV_SIMUL_PAIR_A; // RL10
    else if (b_conc)
      new_adv = fault_monitor_pkg::ADV_CONC_PAIR_B; // RL9
    else if (b_simul)
      new_adv = fault_monitor_pkg::ADV_SIMUL_PAIR_B; // RL10
    else if (outer_conc)
      new_adv = fault_monitor_pkg::ADV_CONC_OUTER; // RL5 RL6
    else
      new_adv = fault_monitor_pkg::ADV_SIMUL_OUTER; // RL7 RL8
  end

  // the first fault keeps its code; a new one while held only blocks its release
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      in_valid <= 1'b0;
      in_adv   <= fault_monitor_pkg::ERR_NONE;
    end
    else if (any_new && !in_valid)
    begin
      in_valid <= 1'b1;
      in_adv   <= new_adv;
    end
    else if (!any_new && !any_lock)
      in_valid <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // sequence timing fault, held until reset
  // ----------------------------------------------------------------------
  logic seq_fault;

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      seq_fault <= 1'b0;
    else if (seq_err_in)
      seq_fault <= 1'b1; // RL11
  end

  // ----------------------------------------------------------------------
  // code selection and index
  // ----------------------------------------------------------------------
  logic [7:0]  next_err;
  logic [7:0]  next_adv;
  logic [15:0] next_index;

  always_comb
  begin
    if (seq_fault)
    begin
      next_err = fault_monitor_pkg::ERR_OUTPUT; // RL11 RL4
      next_adv = fault_monitor_pkg::ADV_SEQ_TIMING;
    end
    else if (in_valid)
    begin
      next_err = fault_monitor_pkg::ERR_INPUT; // RL1
      next_adv = in_adv;
    end
    else
    begin
      next_err = fault_monitor_pkg::ERR_NONE;
      next_adv = fault_monitor_pkg::ERR_NONE;
    end
    next_index = 16'({8'h00, next_err} * fault_monitor_pkg::INDEX_MAJOR_MUL)
                 + {8'h00, next_adv}; // RL2 RL4
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      err_code_out  <= fault_monitor_pkg::ERR_NONE;
      adv_code_out  <= fault_monitor_pkg::ERR_NONE;
      msg_index_out <= '0;
      fault_out     <= 1'b0;
      seq_fault_out <= 1'b0;
      fault_new_out <= 1'b0;
    end
    else
    begin
      err_code_out  <= next_err; // RL1
      adv_code_out  <= next_adv;
      msg_index_out <= next_index; // RL3
      fault_out     <= seq_fault | in_valid;
      seq_fault_out <= seq_fault;
      fault_new_out <= (any_new && !in_valid) || (seq_err_in && !seq_fault);
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      run_out <= 1'b0;
    else
      run_out <= outer_run && !any_lock && !in_valid && !seq_fault &&
                 (!dual_comp || (a_run && b_run)); // RL12
  end

endmodule : dual_input_fault_monitor
`default_nettype wire

// File: verif/fault_monitor_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module fault_monitor_asserts (
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic [3:0]  chan_in,
  input  wire logic [1:0]  mode_in,
  input  wire logic        seq_err_in,
  input  wire logic        run_out,
  input  wire logic        fault_out,
  input  wire logic        fault_new_out,
  input  wire logic        seq_fault_out,
  input  wire logic [7:0]  err_code_out,
  input  wire logic [7:0]  adv_code_out,
  input  wire logic [15:0] msg_index_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  // ----------------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------------
  sequence s_seq_req;
    seq_err_in;
  endsequence
  sequence s_seq_shown;
    seq_fault_out && err_code_out == fault_monitor_pkg::ERR_OUTPUT
      && adv_code_out == fault_monitor_pkg::ADV_SEQ_TIMING;
  endsequence

  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  property p_index;
    msg_index_out == 16'({8'h00, err_code_out} * fault_monitor_pkg::INDEX_MAJOR_MUL
      + {8'h00, adv_code_out});
  endproperty
  property p_seq_report;
    s_seq_req |-> ##2 s_seq_shown;
  endproperty
  property p_seq_hold;
    seq_fault_out |=> seq_fault_out && msg_index_out == 16'h006E;
  endproperty
  property p_fault_flag;
    fault_out == (err_code_out != 8'h00);
  endproperty
  property p_rose_new;
    $rose(fault_out) |-> $past(fault_new_out);
  endproperty
  property p_input_minor;
    err_code_out == fault_monitor_pkg::ERR_INPUT |-> adv_code_out inside {[8'h01:8'h06]};
  endproperty
  property p_run_clear;
    run_out |-> !fault_out;
  endproperty
  property p_seq_over;
    seq_fault_out |-> fault_out && !run_out;
  endproperty

  a_index:       assert property (p_index)       else $error("index not major*100+minor");
  a_seq_report:  assert property (p_seq_report)  else $error("timing error code missing");
  a_seq_hold:    assert property (p_seq_hold)    else $error("timing error code dropped");
  a_fault_flag:  assert property (p_fault_flag)  else $error("fault flag and code differ");
  a_rose_new:    assert property (p_rose_new)    else $error("fault without new pulse");
  a_input_minor: assert property (p_input_minor) else $error("input minor out of range");
  a_run_clear:   assert property (p_run_clear)   else $error("run while fault shown");
  a_seq_over:    assert property (p_seq_over)    else $error("timing error not a fault");
endmodule : fault_monitor_asserts

bind dual_input_fault_monitor fault_monitor_asserts u_fault_monitor_asserts (
  .clk_in(clk_in), .srst_in(srst_in), .chan_in(chan_in), .mode_in(mode_in),
  .seq_err_in(seq_err_in), .run_out(run_out), .fault_out(fault_out),
  .fault_new_out(fault_new_out), .seq_fault_out(seq_fault_out),
  .err_code_out(err_code_out), .adv_code_out(adv_code_out), .msg_index_out(msg_index_out)
);
`default_nettype wire

// File: verif/field_inputs.sv
`timescale 1ns/100ps
`default_nettype none
module field_inputs (
  input  wire logic       clk_in,
  input  wire logic [3:0] run_req_in,
  input  wire logic [1:0] mode_in,
  output logic      [3:0] chan_out
);
  // complementary members sit low in run
  always_ff @(posedge clk_in)
  begin
    case (mode_in)
      fault_monitor_pkg::MODE_COMPL:     chan_out <= run_req_in ^ 4'h2;
      fault_monitor_pkg::MODE_DUAL_COMP: chan_out <= run_req_in ^ 4'hA;
      default:                           chan_out <= run_req_in;
    endcase
  end
endmodule : field_inputs
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int unsigned TICKS = 4;
  localparam int unsigned SIM_MS = 5;
  localparam int unsigned PAIR_LIM = 2;
  logic        clk_in     = 1'b0;
  logic        srst_in    = 1'b1;
  logic [3:0]  run_req    = 4'h0;
  logic [1:0]  mode_in    = 2'h0;
  logic        seq_err_in = 1'b0;
  logic [3:0]  chan_in;
  logic        run_out;
  logic        fault_out;
  logic        fault_new_out;
  logic        seq_fault_out;
  logic [7:0]  err_code_out;
  logic [7:0]  adv_code_out;
  logic [15:0] msg_index_out;
  int          errors      = 0;
  int          checks_done = 0;

  always #2.5 clk_in = ~clk_in;

  field_inputs u_field_inputs (.clk_in(clk_in), .run_req_in(run_req), .mode_in(mode_in),
    .chan_out(chan_in));

  dual_input_fault_monitor #(.TICK_CYCLES(TICKS), .SIMUL_MS(SIM_MS), .PAIR_MS(PAIR_LIM))
  u_dual_input_fault_monitor (.clk_in(clk_in), .srst_in(srst_in), .chan_in(chan_in),
    .mode_in(mode_in), .seq_err_in(seq_err_in), .run_out(run_out), .fault_out(fault_out),
    .fault_new_out(fault_new_out), .seq_fault_out(seq_fault_out),
    .err_code_out(err_code_out), .adv_code_out(adv_code_out),
    .msg_index_out(msg_index_out));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task check(input logic [15:0] seen, input logic [15:0] expected, input string what);
    checks_done++;
    if (seen !== expected)
    begin
      errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, expected);
    end
  endtask : check

  task step(input int n);
    repeat (n)
    begin
      @(posedge clk_in);
      #1;
    end
  endtask : step

  task do_reset();
    srst_in = 1'b1;
    run_req = 4'h0;
    step(12);
    srst_in = 1'b0;
    step(1);
    check(msg_index_out, 16'h0000, "index after reset");
    check(16'({fault_out, run_out, seq_fault_out}), 16'h0000, "flags after reset");
  endtask : do_reset

  task expect_fault(input logic [1:0] mode, input logic [3:0] start, input logic [3:0] mid,
                    input logic [3:0] fin, input logic [3:0] full, input logic [7:0] adv,
                    input int lo, input int hi);
    int n;
    do_reset();
    mode_in = mode;
    run_req = start;
    step(10);
    run_req = mid;
    step(10);
    run_req = fin;
    n = 0;
    while (fault_new_out !== 1'b1 && n < hi)
    begin
      step(1);
      n++;
    end
    check(16'(fault_new_out), 16'h0001, "fault pulse");
    check(16'(n >= lo), 16'h0001, "fault too early");
    // codes follow the pulse by one cycle
    step(1);
    check(16'({fault_new_out, fault_out}), 16'h0001, "pulse over, fault shown");
    check(16'(err_code_out), 16'h0002, "major code");
    check(16'(adv_code_out), 16'(adv), "minor code");
    check(msg_index_out, 16'h00C8 + 16'(adv), "message index");
    run_req = full;
    step(10);
    check(16'({run_out, fault_out}), 16'h0001, "locked after fault");
    run_req = 4'h0;
    step(10);
    check(msg_index_out, 16'h0000, "cleared after stop");
    check(16'(fault_out), 16'h0000, "fault flag cleared after stop");
    run_req = full;
    step(10);
    check(16'(run_out), 16'h0001, "run after restart");
  endtask : expect_fault

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task t_conc_dual();
    expect_fault(2'h0, 4'h3, 4'h2, 4'h3, 4'h3, 8'h01, 4, 6);
  endtask : t_conc_dual

  task t_swap_lock();
    do_reset();
    mode_in = 2'h0;
    run_req = 4'h3;
    step(10);
    run_req = 4'h2;
    step(10);
    run_req = 4'h1;
    step(10);
    check(16'({run_out, fault_out, fault_new_out}), 16'h0000, "swap locks silently");
    run_req = 4'h3;
    step(10);
    check(16'({run_out, fault_out}), 16'h0000, "swap lock holds");
    run_req = 4'h0;
    step(10);
    run_req = 4'h3;
    step(10);
    check(16'(run_out), 16'h0001, "run after swap restart");
  endtask : t_swap_lock

  task t_conc_compl();
    expect_fault(2'h1, 4'h3, 4'h1, 4'h3, 4'h3, 8'h01, 4, 6);
  endtask : t_conc_compl

  task t_simul_dual();
    expect_fault(2'h0, 4'h0, 4'h0, 4'h1, 4'h3, 8'h02, (SIM_MS - 1) * TICKS,
                 (SIM_MS + 1) * TICKS + 8);
    expect_fault(2'h1, 4'h0, 4'h0, 4'h2, 4'h3, 8'h02, (SIM_MS - 1) * TICKS,
                 (SIM_MS + 1) * TICKS + 8);
  endtask : t_simul_dual

  task t_dc_outer();
    expect_fault(2'h2, 4'hF, 4'hC, 4'hF, 4'hF, 8'h01, 4, 6);
    expect_fault(2'h2, 4'h0, 4'h0, 4'h3, 4'hF, 8'h02, (SIM_MS - 1) * TICKS,
                 (SIM_MS + 1) * TICKS + 8);
  endtask : t_dc_outer

  task t_dc_pair();
    expect_fault(2'h2, 4'hF, 4'hE, 4'hF, 4'hF, 8'h03, 4, 6);
    expect_fault(2'h2, 4'hF, 4'hB, 4'hF, 4'hF, 8'h05, 4, 6);
    expect_fault(2'h2, 4'h0, 4'h0, 4'h1, 4'hF, 8'h04, (PAIR_LIM - 1) * TICKS,
                 (PAIR_LIM + 1) * TICKS + 8);
    expect_fault(2'h2, 4'h0, 4'h0, 4'h4, 4'hF, 8'h06, (PAIR_LIM - 1) * TICKS,
                 (PAIR_LIM + 1) * TICKS + 8);
  endtask : t_dc_pair

  task t_seq_hold();
    do_reset();
    mode_in = 2'h0;
    run_req = 4'h3;
    step(10);
    seq_err_in = 1'b1;
    step(1);
    seq_err_in = 1'b0;
    step(3);
    check(16'({seq_fault_out, err_code_out}), 16'h0101, "timing major");
    check(16'(adv_code_out), 16'h000A, "timing minor");
    check(msg_index_out, 16'h006E, "timing index");
    run_req = 4'h0;
    step(10);
    run_req = 4'h3;
    step(20);
    check(msg_index_out, 16'h006E, "timing error held");
    check(16'({run_out, fault_out}), 16'h0001, "no run under timing error");
    do_reset();
  endtask : t_seq_hold

  task results();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  initial
  begin
    t_conc_dual();
    t_swap_lock();
    t_conc_compl();
    t_simul_dual();
    t_dc_outer();
    t_dc_pair();
    t_seq_hold();
    results();
  end

  initial
  begin
    #50000;
    errors++;
    results();
  end
endmodule : tb_top
`default_nettype wire
